// ===== hdl/bsdr_fuse_load.sv
`timescale 1ns/1ps

// Captures the fuse image once after reset release and marks it loaded
module bsdr_fuse_load
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire bsdr_pkg::bsdr_fuse_type fuse_i,
   output logic load_o,
   output bsdr_pkg::bsdr_fuse_type image_o
);

   logic done;

   // One-shot load strobe; fuse value is caught by the clock, not the reset
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         done <= 1'b0;
         load_o <= 1'b0;
      end
      else
      begin
         done <= 1'b1;
         load_o <= !done;
      end
   end

   // Image register, sampled on the first edge after release
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         image_o <= '0;
      else if (!done)
         image_o <= fuse_i;
   end

endmodule

// ===== hdl/bsdr_pkg.sv
package bsdr_pkg;

   // ***************************************************************
   // Bus and register map
   // ***************************************************************
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned REG_W = 8;

   // Printed offsets are not all multiples of four: they are indices
   localparam logic [7:0] IDX_BUCK3_CONTROL = 8'h41;
   localparam logic [7:0] IDX_BUCK3_CONTROL_LIMITS = 8'h42;
   localparam logic [7:0] IDX_RTC_SUPPLY_CONTROL = 8'h48;
   localparam logic [7:0] IDX_DDR_REFERENCE_CONTROL = 8'h4a;
   localparam logic [7:0] IDX_OPERATING_MODE = 8'h80;
   localparam logic [7:0] IDX_REGULATOR_STATUS = 8'h81;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int unsigned B3_RUN_EN_BIT = 0;
   localparam int unsigned B3_STBY_EN_BIT = 1;
   localparam int unsigned B3_SLEEP_EN_BIT = 2;
   localparam int unsigned B3_LPWR_BIT = 3;
   localparam int unsigned B3_FPWM_BIT = 6;
   localparam int unsigned B3_RDIS_OFF_BIT = 7;
   localparam int unsigned B3_ILIM_LSB = 0;
   localparam int unsigned B3_TSEL_BIT = 4;
   localparam int unsigned RTC_VOLT_LSB = 0;
   localparam int unsigned RTC_EVAL_BIT = 3;
   localparam int unsigned RTC_FBOS_BIT = 4;
   localparam int unsigned RTC_BGDIS_BIT = 5;
   localparam int unsigned DDR_EN_BIT = 0;
   localparam int unsigned DDR_STBY_EN_BIT = 1;
   localparam int unsigned DDR_SLEEP_EN_BIT = 2;
   localparam int unsigned DDR_LPWR_BIT = 3;

   // Writable bits of each register; all others read zero
   localparam logic [7:0] MASK_BUCK3_CONTROL = 8'hcf;
   localparam logic [7:0] MASK_BUCK3_CONTROL_LIMITS = 8'h13;
   localparam logic [7:0] MASK_RTC_SUPPLY_CONTROL = 8'h3f;
   localparam logic [7:0] MASK_DDR_REFERENCE_CONTROL = 8'h0f;
   localparam logic [7:0] MASK_OPERATING_MODE = 8'h03;

   // Bits that the fuse preload supplies at power-up
   localparam logic [7:0] FUSE_BUCK3_CONTROL = 8'h83;
   localparam logic [7:0] FUSE_BUCK3_CONTROL_LIMITS = 8'h03;
   localparam logic [7:0] FUSE_RTC_SUPPLY_CONTROL = 8'h07;
   localparam logic [7:0] FUSE_DDR_REFERENCE_CONTROL = 8'h03;

   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;

   // ***************************************************************
   // Types
   // ***************************************************************
   typedef enum logic [1:0] {
      BSDR_MODE_RUN     = 2'h0,
      BSDR_MODE_STANDBY = 2'h1,
      BSDR_MODE_SLEEP   = 2'h3,
      BSDR_MODE_OFF     = 2'h2
   } bsdr_mode_type;

   // Fuse image presented at power-up
   typedef struct packed {
      logic [7:0] buck3_control;
      logic [7:0] buck3_control_limits;
      logic [7:0] rtc_supply_control;
      logic [7:0] ddr_reference_control;
   } bsdr_fuse_type;

   // Analog controls to the buck3 converter
   typedef struct packed {
      logic enable;
      logic low_power;
      logic forced_pwm;
      logic discharge_on;
      logic [1:0] current_limit;
      logic timing_select;
   } bsdr_buck3_type;

   // Analog controls to the RTC supply and DDR reference
   typedef struct packed {
      logic [2:0] rtc_supply_voltage_field;
      logic eval_pulse_bit;
      logic force_supply_selector;
      logic coin_bandgap_disable;
      logic ddr_ref_enable;
      logic ddr_ref_low_power;
   } bsdr_aux_type;

endpackage

// ===== hdl/bsdr_regs.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - Buck3 bit0 enables Run; fuse preload, clearable.
// - Buck3 bit1 enables Standby; fuse preload, clearable.
// - Buck3 bit2 enables Sleep; read/write, reset 0.
// - Buck3 bit3 low-power in Standby/Sleep.
// - Buck3 bit6 forces continuous PWM.
// - Buck3 bit7 low connects discharge when off.
// - Two-bit current limit, 1.0 to 2.0 A.
// - RTC voltage field stored, no function.
// - RTC bit4 forces best-supply selector always.
// - RTC bit5 disables coin-cell local bandgap.
// - RTC bit3 evaluation bit, reset 0.
// - DDR bit0 enables reference; fuse sets it.
// - DDR Standby needs bit1 and main enable.
// - DDR Sleep needs bit2 and main enable.
// - DDR bit3 selects reference low power.
// - Fuse-loaded fields preload, then software read/write.
module bsdr_regs
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [bsdr_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [bsdr_pkg::DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic pready_o,
   output logic [bsdr_pkg::DATA_W-1:0] prdata_o,
   output logic pslverr_o,
   // Fuse image, held stable from power-up
   input wire bsdr_pkg::bsdr_fuse_type fuse_i,
   // Operating mode from the power sequencer
   input wire bsdr_pkg::bsdr_mode_type mode_i,
   // System supply below undervoltage threshold (asynchronous comparator)
   input wire logic system_supply_low_i,
   // Running from the coin cell (asynchronous comparator)
   input wire logic coin_cell_mode_i,
   output bsdr_pkg::bsdr_buck3_type buck3_o,
   output bsdr_pkg::bsdr_aux_type aux_o,
   output logic best_supply_selector_o,
   output logic rtc_bandgap_on_o
);

   // ***************************************************************
   // Declarations
   // ***************************************************************
   logic [7:0] buck3_control;
   logic [7:0] buck3_control_limits;
   logic [7:0] rtc_supply_control;
   logic [7:0] ddr_reference_control;
   logic [7:0] sw_mode;
   logic fuse_load;
   bsdr_pkg::bsdr_fuse_type fuse_image;
   logic [1:0] uv_sync;
   logic [1:0] coin_sync;
   logic access;
   logic wr_en;
   logic hit;
   logic [7:0] wbyte;
   logic [7:0] idx;
   logic [7:0] next_rdata;
   bsdr_pkg::bsdr_mode_type eff_mode;

   // Register index from the word address
   function automatic logic [7:0] word_index(input logic [bsdr_pkg::ADDR_W-1:0] a);
      word_index = a[9:2];
   endfunction

   // Masked merge of write data into a register
   function automatic logic [7:0] merge(input logic [7:0] d, input logic [7:0] m);
      merge = d & m;
   endfunction

   // ***************************************************************
   // Fuse preload
   // ***************************************************************
   bsdr_fuse_load u_fuse
   (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .fuse_i(fuse_i),
      .load_o(fuse_load),
      .image_o(fuse_image)
   );

   // ***************************************************************
   // APB decode
   // ***************************************************************
   assign idx = word_index(paddr_i);
   assign access = psel_i && penable_i;
   assign wr_en = access && pwrite_i && pstrb_i[0] && hit;
   assign wbyte = pwdata_i[7:0];
   // Upper address bits must be zero and the word must be aligned
   assign hit = (paddr_i[1:0] == 2'h0) && (paddr_i[bsdr_pkg::ADDR_W-1:10] == '0) &&
                ((idx == bsdr_pkg::IDX_BUCK3_CONTROL) || (idx == bsdr_pkg::IDX_BUCK3_CONTROL_LIMITS) ||
                 (idx == bsdr_pkg::IDX_RTC_SUPPLY_CONTROL) || (idx == bsdr_pkg::IDX_DDR_REFERENCE_CONTROL) ||
                 (idx == bsdr_pkg::IDX_OPERATING_MODE) || (idx == bsdr_pkg::IDX_REGULATOR_STATUS));

   // ***************************************************************
   // Register storage
   // ***************************************************************
   // Buck3 control; fuse bits override only during the load cycle
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         buck3_control <= bsdr_pkg::RESET_ZERO;
      else if (fuse_load)
         buck3_control <= fuse_image.buck3_control & bsdr_pkg::FUSE_BUCK3_CONTROL;
      else if (wr_en && idx == bsdr_pkg::IDX_BUCK3_CONTROL)
         buck3_control <= merge(wbyte, bsdr_pkg::MASK_BUCK3_CONTROL);
   end

   // Buck3 limits and timing select
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         buck3_control_limits <= bsdr_pkg::RESET_ZERO;
      else if (fuse_load)
         buck3_control_limits <= fuse_image.buck3_control_limits & bsdr_pkg::FUSE_BUCK3_CONTROL_LIMITS;
      else if (wr_en && idx == bsdr_pkg::IDX_BUCK3_CONTROL_LIMITS)
         buck3_control_limits <= merge(wbyte, bsdr_pkg::MASK_BUCK3_CONTROL_LIMITS);
   end

   // RTC supply control
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rtc_supply_control <= bsdr_pkg::RESET_ZERO;
      else if (fuse_load)
         rtc_supply_control <= fuse_image.rtc_supply_control & bsdr_pkg::FUSE_RTC_SUPPLY_CONTROL;
      else if (wr_en && idx == bsdr_pkg::IDX_RTC_SUPPLY_CONTROL)
         rtc_supply_control <= merge(wbyte, bsdr_pkg::MASK_RTC_SUPPLY_CONTROL);
   end

   // DDR reference control
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         ddr_reference_control <= bsdr_pkg::RESET_ZERO;
      else if (fuse_load)
         ddr_reference_control <= fuse_image.ddr_reference_control & bsdr_pkg::FUSE_DDR_REFERENCE_CONTROL;
      else if (wr_en && idx == bsdr_pkg::IDX_DDR_REFERENCE_CONTROL)
         ddr_reference_control <= merge(wbyte, bsdr_pkg::MASK_DDR_REFERENCE_CONTROL);
   end

   // Software mode override; writing Run hands control back to mode_i
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         sw_mode <= bsdr_pkg::RESET_ZERO;
      else if (wr_en && idx == bsdr_pkg::IDX_OPERATING_MODE)
         sw_mode <= merge(wbyte, bsdr_pkg::MASK_OPERATING_MODE);
   end

   // ***************************************************************
   // Synchronisers for the analog comparators
   // ***************************************************************
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         uv_sync <= 2'h0;
         coin_sync <= 2'h0;
      end
      else
      begin
         uv_sync <= {uv_sync[0], system_supply_low_i};
         coin_sync <= {coin_sync[0], coin_cell_mode_i};
      end
   end

   // Effective mode: a nonzero software override wins over the sequencer
   assign eff_mode = (sw_mode[1:0] != 2'h0) ? bsdr_pkg::bsdr_mode_type'(sw_mode[1:0]) : mode_i;

   // ***************************************************************
   // Read path
   // ***************************************************************
   always_comb
   begin
      next_rdata = bsdr_pkg::RESET_ZERO;
      unique case (idx)
         bsdr_pkg::IDX_BUCK3_CONTROL: next_rdata = buck3_control;
         bsdr_pkg::IDX_BUCK3_CONTROL_LIMITS: next_rdata = buck3_control_limits;
         bsdr_pkg::IDX_RTC_SUPPLY_CONTROL: next_rdata = rtc_supply_control;
         bsdr_pkg::IDX_DDR_REFERENCE_CONTROL: next_rdata = ddr_reference_control;
         bsdr_pkg::IDX_OPERATING_MODE: next_rdata = sw_mode;
         // Live state: buck on, ddr on, bandgap on, selector, effective mode
         bsdr_pkg::IDX_REGULATOR_STATUS: next_rdata = {2'h0, eff_mode, best_supply_selector_o,
                                                      rtc_bandgap_on_o, aux_o.ddr_ref_enable, buck3_o.enable};
         default: next_rdata = bsdr_pkg::RESET_ZERO;
      endcase
   end

   // APB answer: zero wait states, error on unmapped addresses
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= bsdr_pkg::READ_ZERO;
      end
      else
      begin
         // Ready drops right after the access so the next setup sees it low
         pready_o <= psel_i && !penable_i;
         pslverr_o <= psel_i && !penable_i && !hit;
         prdata_o <= (psel_i && !penable_i && !pwrite_i && hit) ? {24'h0, next_rdata} : bsdr_pkg::READ_ZERO;
      end
   end

   // ***************************************************************
   // Regulator control outputs
   // ***************************************************************
   // Buck3 enable follows the mode; low power only in Standby and Sleep
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         buck3_o <= '0;
      else
      begin
         unique case (eff_mode)
            bsdr_pkg::BSDR_MODE_RUN: buck3_o.enable <= buck3_control[bsdr_pkg::B3_RUN_EN_BIT];
            bsdr_pkg::BSDR_MODE_STANDBY: buck3_o.enable <= buck3_control[bsdr_pkg::B3_STBY_EN_BIT];
            bsdr_pkg::BSDR_MODE_SLEEP: buck3_o.enable <= buck3_control[bsdr_pkg::B3_SLEEP_EN_BIT];
            bsdr_pkg::BSDR_MODE_OFF: buck3_o.enable <= 1'b0;
         endcase
         buck3_o.low_power <= buck3_control[bsdr_pkg::B3_LPWR_BIT] &&
                              (eff_mode == bsdr_pkg::BSDR_MODE_STANDBY || eff_mode == bsdr_pkg::BSDR_MODE_SLEEP);
         buck3_o.forced_pwm <= buck3_control[bsdr_pkg::B3_FPWM_BIT];
         buck3_o.discharge_on <= !buck3_control[bsdr_pkg::B3_RDIS_OFF_BIT] && !buck3_o.enable;
         buck3_o.current_limit <= buck3_control_limits[bsdr_pkg::B3_ILIM_LSB +: 2];
         buck3_o.timing_select <= buck3_control_limits[bsdr_pkg::B3_TSEL_BIT];
      end
   end

   // RTC supply and DDR reference controls
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         aux_o <= '0;
      else
      begin
         aux_o.rtc_supply_voltage_field <= rtc_supply_control[bsdr_pkg::RTC_VOLT_LSB +: 3];
         aux_o.eval_pulse_bit <= rtc_supply_control[bsdr_pkg::RTC_EVAL_BIT];
         aux_o.force_supply_selector <= rtc_supply_control[bsdr_pkg::RTC_FBOS_BIT];
         aux_o.coin_bandgap_disable <= rtc_supply_control[bsdr_pkg::RTC_BGDIS_BIT];
         // Run, Standby, Sleep, all need main enable
         unique case (eff_mode)
            bsdr_pkg::BSDR_MODE_RUN: aux_o.ddr_ref_enable <= ddr_reference_control[bsdr_pkg::DDR_EN_BIT];
            bsdr_pkg::BSDR_MODE_STANDBY: aux_o.ddr_ref_enable <= ddr_reference_control[bsdr_pkg::DDR_EN_BIT] &&
                                                               ddr_reference_control[bsdr_pkg::DDR_STBY_EN_BIT];
            bsdr_pkg::BSDR_MODE_SLEEP: aux_o.ddr_ref_enable <= ddr_reference_control[bsdr_pkg::DDR_EN_BIT] &&
                                                             ddr_reference_control[bsdr_pkg::DDR_SLEEP_EN_BIT];
            bsdr_pkg::BSDR_MODE_OFF: aux_o.ddr_ref_enable <= 1'b0;
         endcase
         aux_o.ddr_ref_low_power <= ddr_reference_control[bsdr_pkg::DDR_LPWR_BIT];
      end
   end

   // Best-supply selector and bandgap, from synchronised comparators
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         best_supply_selector_o <= 1'b0;
         rtc_bandgap_on_o <= 1'b1;
      end
      else
      begin
         best_supply_selector_o <= rtc_supply_control[bsdr_pkg::RTC_FBOS_BIT] || uv_sync[1];
         rtc_bandgap_on_o <= !(rtc_supply_control[bsdr_pkg::RTC_BGDIS_BIT] && coin_sync[1]);
      end
   end

endmodule

// ===== testbench/bsdr_regs_properties.sv
`timescale 1ns/1ps

// ***************************************************************
// Port checker for the control register bank
// ***************************************************************
module bsdr_regs_properties
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [bsdr_pkg::ADDR_W-1:0] paddr_i,
   input wire logic [bsdr_pkg::DATA_W-1:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic pready_o,
   input wire logic [bsdr_pkg::DATA_W-1:0] prdata_o,
   input wire logic pslverr_o,
   input wire bsdr_pkg::bsdr_buck3_type buck3_o,
   input wire bsdr_pkg::bsdr_aux_type aux_o,
   input wire logic best_supply_selector_o,
   input wire logic rtc_bandgap_on_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);

   // Accepted write; outputs show it two sampling edges later
   logic wr_acc;
   assign wr_acc = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && !pslverr_o;

   limit_follow_a: assert property (
      wr_acc && paddr_i == 12'h108 |=> ##1 buck3_o.current_limit == $past(pwdata_i[1:0], 2)
      && buck3_o.timing_select == $past(pwdata_i[4], 2)) else $error("Limit or timing select stale");
   pwm_follow_a: assert property (
      wr_acc && paddr_i == 12'h104 |=> ##1 buck3_o.forced_pwm == $past(pwdata_i[6], 2))
      else $error("Forced PWM stale");
   buck_off_a: assert property (
      wr_acc && paddr_i == 12'h104 && pwdata_i[2:0] == 3'h0 |=> ##1 !buck3_o.enable)
      else $error("Buck3 on with all enables clear");
   discharge_gate_a: assert property (
      buck3_o.discharge_on |-> !$past(buck3_o.enable)) else $error("Discharge while enabled");
   rtc_fields_a: assert property (
      wr_acc && paddr_i == 12'h120 |=> ##1 aux_o.rtc_supply_voltage_field == $past(pwdata_i[2:0], 2)
      && aux_o.eval_pulse_bit == $past(pwdata_i[3], 2)) else $error("RTC fields stale");
   force_sel_a: assert property (
      aux_o.force_supply_selector && $past(aux_o.force_supply_selector) |-> best_supply_selector_o)
      else $error("Selector idle while forced");
   bandgap_keep_a: assert property (
      !aux_o.coin_bandgap_disable && $past(!aux_o.coin_bandgap_disable) |-> rtc_bandgap_on_o)
      else $error("Bandgap off without disable");
   ddr_off_a: assert property (
      wr_acc && paddr_i == 12'h128 && !pwdata_i[0] |=> ##1 !aux_o.ddr_ref_enable)
      else $error("Reference on with main enable clear");
   ddr_lp_a: assert property (
      wr_acc && paddr_i == 12'h128 |=> ##1 aux_o.ddr_ref_low_power == $past(pwdata_i[3], 2))
      else $error("Reference low power stale");
   upper_zero_a: assert property (
      pready_o |-> prdata_o[31:8] == 24'h0 && (!pslverr_o || prdata_o == 32'h0))
      else $error("Unused read bits set");

   limit_write_c: cover property (wr_acc && paddr_i == 12'h108);
   discharge_c: cover property (buck3_o.discharge_on);
   refused_c: cover property (pready_o && pslverr_o);
endmodule

bind bsdr_regs bsdr_regs_properties u_bsdr_regs_properties
(
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o), .buck3_o(buck3_o),
   .aux_o(aux_o), .best_supply_selector_o(best_supply_selector_o), .rtc_bandgap_on_o(rtc_bandgap_on_o)
);

// ===== testbench/bsdr_tb_top.sv
`timescale 1ns/1ps

module buck3_snvs_ddrref_ctrl_regs_tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'h0;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   bsdr_pkg::bsdr_fuse_type fuse;
   bsdr_pkg::bsdr_mode_type mode = bsdr_pkg::BSDR_MODE_RUN;
   logic sup_low = 1'b0;
   logic coin = 1'b0;
   bsdr_pkg::bsdr_buck3_type buck3;
   bsdr_pkg::bsdr_aux_type aux;
   logic bss;
   logic bg_on;
   int error_cnt = 0;
   int num_checks = 0;
   logic [11:0] adr [8];
   logic [7:0] msk [5];
   logic [7:0] mr [8];

   // Free-running 20 MHz clock
   initial
   begin
      forever #25 clk = ~clk;
   end

   bsdr_regs u_bsdr_regs
   (
      .sys_clk_i(clk), .resetn_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata),
      .pslverr_o(pslverr), .fuse_i(fuse), .mode_i(mode), .system_supply_low_i(sup_low),
      .coin_cell_mode_i(coin), .buck3_o(buck3), .aux_o(aux), .best_supply_selector_o(bss),
      .rtc_bandgap_on_o(bg_on)
   );

   // ***************************************************************
   // Checking and reporting
   // ***************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("Checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // APB transfer; hold keeps psel up for a following setup cycle
   task automatic apb(input logic wr, input int k, input logic [7:0] d, input logic [3:0] st, input logic hold);
      int n;
      logic ok;
      n = 0;
      // Index 7 is the read-only status word, mapped but not in the write table
      ok = (k < 5) || (k == 7);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= adr[k];
      pwdata <= {24'($urandom), d};
      pstrb <= st;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         n++;
         @(posedge clk);
      end
      if (n == 20)
      begin
         error_cnt++;
         summarize();
      end
      chk("pslverr", {31'h0, pslverr}, {31'h0, !ok});
      if (!wr)
         chk("prdata", prdata, {24'h0, ok ? mr[k] : 8'h00});
      if (wr && ok && st[0])
         mr[k] = d & msk[k];
      penable <= 1'b0;
      if (!hold)
      begin
         psel <= 1'b0;
         @(posedge clk);
      end
   endtask

   // Model of the analog controls; waits out the input synchronisers
   task automatic outs();
      logic [1:0] m;
      bsdr_pkg::bsdr_buck3_type eb;
      bsdr_pkg::bsdr_aux_type ea;
      m = (mr[4][1:0] != 2'h0) ? mr[4][1:0] : mode;
      eb.enable = (m == 2'h0) ? mr[0][0] : (m == 2'h1) ? mr[0][1] : (m == 2'h3) ? mr[0][2] : 1'b0;
      eb.low_power = mr[0][3] && m[0];
      eb.forced_pwm = mr[0][6];
      eb.discharge_on = !mr[0][7] && !eb.enable;
      eb.current_limit = mr[1][1:0];
      eb.timing_select = mr[1][4];
      ea.rtc_supply_voltage_field = mr[2][2:0];
      ea.eval_pulse_bit = mr[2][3];
      ea.force_supply_selector = mr[2][4];
      ea.coin_bandgap_disable = mr[2][5];
      ea.ddr_ref_enable = mr[3][0] && (m == 2'h0 || (m == 2'h1 && mr[3][1]) || (m == 2'h3 && mr[3][2]));
      ea.ddr_ref_low_power = mr[3][3];
      repeat (5) @(posedge clk);
      chk("buck3", 32'(buck3), 32'(eb));
      chk("aux", 32'(aux), 32'(ea));
      chk("selector", 32'(bss), 32'(mr[2][4] | sup_low));
      chk("bandgap", 32'(bg_on), 32'(!(mr[2][5] && coin)));
      // Live status word, read back over the bus
      mr[7] = {2'h0, m, mr[2][4] | sup_low, !(mr[2][5] && coin), ea.ddr_ref_enable, eb.enable};
      apb(1'b0, 7, 8'h00, 4'hf, 1'b0);
   endtask

   // Reset, then read back the fuse preload
   task automatic do_reset();
      bsdr_pkg::bsdr_fuse_type f;
      f = $urandom;
      f.ddr_reference_control[1] = f.ddr_reference_control[0];
      fuse <= f;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk("rst_buck3", 32'(buck3), 32'h0);
      chk("rst_bandgap", 32'(bg_on), 32'h1);
      rst_n <= 1'b1;
      mr = '{fuse.buck3_control & bsdr_pkg::FUSE_BUCK3_CONTROL,
             fuse.buck3_control_limits & bsdr_pkg::FUSE_BUCK3_CONTROL_LIMITS,
             fuse.rtc_supply_control & bsdr_pkg::FUSE_RTC_SUPPLY_CONTROL,
             fuse.ddr_reference_control & bsdr_pkg::FUSE_DDR_REFERENCE_CONTROL, 8'h00,
             8'h00, 8'h00, 8'h00};
      repeat (3) @(posedge clk);
      for (int k = 0; k < 5; k++)
         apb(1'b0, k, 8'h00, 4'hf, 1'b0);
      outs();
   endtask

   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      int k;
      void'($urandom(52));
      adr = '{12'h104, 12'h108, 12'h120, 12'h128, 12'h200, 12'h10c, 12'h105, 12'h204};
      msk = '{bsdr_pkg::MASK_BUCK3_CONTROL, bsdr_pkg::MASK_BUCK3_CONTROL_LIMITS,
              bsdr_pkg::MASK_RTC_SUPPLY_CONTROL, bsdr_pkg::MASK_DDR_REFERENCE_CONTROL,
              bsdr_pkg::MASK_OPERATING_MODE};
      do_reset();
      $display("Test preload done");
      // Random write then back-to-back readback, strobe-less and refused ones among them
      for (int i = 0; i < 60; i++)
      begin
         k = $urandom_range(6, 0);
         apb(1'b1, k, 8'($urandom), ($urandom_range(3, 0) == 0) ? 4'he : 4'hf, 1'b1);
         apb(1'b0, k, 8'h00, 4'hf, 1'b0);
         sup_low <= 1'($urandom);
         coin <= 1'($urandom);
         @(posedge clk);
         outs();
      end
      $display("Test random access done");
      // Every mode, by pin and by override
      for (int m = 0; m < 16; m++)
      begin
         apb(1'b1, m % 2 ? 0 : 3, 8'($urandom), 4'hf, 1'b0);
         apb(1'b1, 4, {6'h00, 2'(m / 4)}, 4'hf, 1'b0);
         mode <= bsdr_pkg::bsdr_mode_type'(m % 4);
         @(posedge clk);
         outs();
      end
      $display("Test modes done");
      do_reset();
      $display("Test second reset done");
      summarize();
   end
endmodule
